// *** logic/fls_regs.vh ***
// Constants for the flash lane function select block: register offsets,
// field positions, reset values, encodings and default counts.
// Included by bare name from the design file; definitions only.
`ifndef FLS_REGS_VH
`define FLS_REGS_VH

// Register byte offsets (AXI4-Lite, one aligned word each)
`define FLS_OFF_CTRL     4'h0
`define FLS_OFF_SREG     4'h4
`define FLS_OFF_STATE    4'h8

// Control register fields and reset value
`define FLS_CTRL_PROTO_LSB  0
`define FLS_CTRL_PROTO_MSB  1
`define FLS_CTRL_DTR        2
`define FLS_CTRL_PAUSE_EN   3
`define FLS_CTRL_RESET      4'h8

// Status register fields and reset value
`define FLS_SR_WR_DISABLE   7
`define FLS_SR_BUSY         0
`define FLS_SR_RESET        8'h00
`define FLS_SR_NV_MASK      8'hFC

// State register: write-one-to-clear refused flag
`define FLS_ST_REFUSED      8

// Protocol and command form encodings
`define FLS_FORM_SINGLE  2'h0
`define FLS_FORM_DUAL    2'h1
`define FLS_FORM_QUAD    2'h2

// Engine phases
`define FLS_PH_CMD       2'h0
`define FLS_PH_WDATA     2'h1
`define FLS_PH_RDATA     2'h2
`define FLS_PH_DONE      2'h3

// Default opcodes and internal status-write cycle length
`define FLS_OP_WR_STATUS   8'h01
`define FLS_OP_RD_STATUS   8'h05
`define FLS_OP_DUAL_OUT    8'h3B
`define FLS_OP_DUAL_IO     8'hBB
`define FLS_OP_QUAD_OUT    8'h6B
`define FLS_OP_QUAD_IO     8'hEB
`define FLS_WSR_CYCLES     16'h0100

// AXI responses
`define FLS_RESP_OKAY    2'h0
`define FLS_RESP_SLVERR  2'h2

`endif

// *** logic/fls_lane_select.v ***
// Lane function select for a multi-lane serial flash device end: lane
// direction per protocol and command form, pause on lane three, write
// protect on lane two, and a status register reached over AXI4-Lite.
// Assumes every serial pin is asynchronous to aclk; the serial clock must
// run well below aclk/4 since its edges are found by sampling.
`timescale 1ns/1ps
`default_nettype none
`include "fls_regs.vh"

module fls_lane_select #(
	parameter [7:0]  OP_WR_STATUS = `FLS_OP_WR_STATUS,
	parameter [7:0]  OP_RD_STATUS = `FLS_OP_RD_STATUS,
	parameter [7:0]  OP_DUAL_OUT  = `FLS_OP_DUAL_OUT,
	parameter [7:0]  OP_DUAL_IO   = `FLS_OP_DUAL_IO,
	parameter [7:0]  OP_QUAD_OUT  = `FLS_OP_QUAD_OUT,
	parameter [7:0]  OP_QUAD_IO   = `FLS_OP_QUAD_IO,
	parameter [15:0] WSR_CYCLES   = `FLS_WSR_CYCLES
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Serial pins
	input  wire        sclk,
	input  wire        cs_n,
	input  wire [3:0]  lane_in,
	output reg  [3:0]  lane_out,
	output reg  [3:0]  lane_oe
);

	function [2:0] fls_w;
		input [1:0] f;
		fls_w = (f == `FLS_FORM_QUAD) ? 3'h4 :
			(f == `FLS_FORM_DUAL) ? 3'h2 : 3'h1;
	endfunction

	function [7:0] fls_shin;
		input [7:0] s;
		input [3:0] l;
		input [1:0] f;
		case (f)
		`FLS_FORM_QUAD: fls_shin = {s[3:0], l};
		`FLS_FORM_DUAL: fls_shin = {s[5:0], l[1:0]};
		default:        fls_shin = {s[6:0], l[0]};
		endcase
	endfunction

	function [3:0] fls_oe;
		input [1:0] f;
		case (f)
		`FLS_FORM_QUAD: fls_oe = 4'hF;
		`FLS_FORM_DUAL: fls_oe = 4'h3;
		default:        fls_oe = 4'h2;
		endcase
	endfunction

	function [3:0] fls_chunk;
		input [7:0] o;
		input [1:0] f;
		case (f)
		`FLS_FORM_QUAD: fls_chunk = o[7:4];
		`FLS_FORM_DUAL: fls_chunk = {2'h0, o[7:6]};
		default:        fls_chunk = {2'h0, o[7], 1'b0};
		endcase
	endfunction

	// Pin synchronisers; the second stage is looked at, and for sclk the third as well
	reg        sclk_s1_r, sclk_s2_r, sclk_s3_r;
	reg        csn_s1_r, csn_s2_r;
	reg  [3:0] lin_s1_r, lin_s2_r;

	// Control and status
	reg  [1:0] proto_r;
	reg        dtr_r;
	reg        pause_en_r;
	reg  [7:0] sr_r;
	reg        refused_r;
	reg [15:0] busy_cnt_r;

	// Serial engine
	reg  [1:0] phase_r;
	reg  [1:0] form_r;
	reg  [3:0] cnt_r;
	reg  [7:0] sh_r;
	reg  [7:0] wdat_r;
	reg        wfull_r;
	reg  [7:0] oreg_r;
	reg        drv_r;
	reg        sel_d_r;
	reg        paused_r;

	// AXI capture
	reg        aw_got_r, w_got_r;
	reg  [3:0] awaddr_r;
	reg [31:0] wdata_r;
	reg  [3:0] wstrb_r;

	wire       sel      = ~csn_s2_r;
	wire       rise     = sclk_s2_r & ~sclk_s3_r;
	wire       fall     = ~sclk_s2_r & sclk_s3_r;
	wire       busy     = (busy_cnt_r != 16'h0000);
	wire [7:0] sr_view  = {sr_r[7:1], busy};
	wire [1:0] proto_form = (proto_r == `FLS_FORM_QUAD) ? `FLS_FORM_QUAD :
		(proto_r == `FLS_FORM_DUAL) ? `FLS_FORM_DUAL : `FLS_FORM_SINGLE;
	// Lane three is data whenever a quad form is in force; double rate turns pause off too
	wire       pause_ok = pause_en_r & ~dtr_r &
		(proto_r != `FLS_FORM_QUAD) & (form_r != `FLS_FORM_QUAD);
	wire       hold     = pause_ok & ~lin_s2_r[3];
	// Protect level is taken from the pin only while it is not lane two
	wire       wp_low   = ~lin_s2_r[2] & (form_r != `FLS_FORM_QUAD);
	wire       protect  = sr_r[`FLS_SR_WR_DISABLE] & wp_low;
	wire [2:0] w        = fls_w(form_r);
	wire [3:0] cnt_sum  = cnt_r + {1'b0, w};
	wire [7:0] sh_nxt   = fls_shin(sh_r, lin_s2_r, form_r);
	wire       in_edge  = rise | (dtr_r & fall);
	wire       out_edge = fall | (dtr_r & rise);
	wire       wr_do    = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire       wr_ctrl  = wr_do & (awaddr_r == `FLS_OFF_CTRL);
	wire       wr_sreg  = wr_do & (awaddr_r == `FLS_OFF_SREG);
	wire       wr_state = wr_do & (awaddr_r == `FLS_OFF_STATE);
	wire       commit   = sel_d_r & ~sel & (phase_r == `FLS_PH_WDATA) &
		wfull_r & ~busy;
	wire       refuse   = commit & protect;
	wire [31:0] state_word = {22'h0, busy, refused_r, phase_r, form_r,
		protect, paused_r, ~sel & ~busy, sel};

	always @(posedge aclk) begin
		sclk_s1_r <= sclk;
		sclk_s2_r <= sclk_s1_r;
		sclk_s3_r <= sclk_s2_r;
		csn_s1_r  <= cs_n;
		csn_s2_r  <= csn_s1_r;
		lin_s1_r  <= lane_in;
		lin_s2_r  <= lin_s1_r;
	end

	// Register file and serial engine share one process so that the
	// status register has a single driver
	always @(posedge aclk) begin
		if (!aresetn) begin
			proto_r    <= `FLS_FORM_SINGLE;
			dtr_r      <= 1'b0;
			pause_en_r <= 1'b1;
			sr_r       <= `FLS_SR_RESET;
			refused_r  <= 1'b0;
			busy_cnt_r <= 16'h0000;
			phase_r    <= `FLS_PH_CMD;
			form_r     <= `FLS_FORM_SINGLE;
			cnt_r      <= 4'h0;
			sh_r       <= 8'h00;
			wdat_r     <= 8'h00;
			wfull_r    <= 1'b0;
			oreg_r     <= 8'h00;
			drv_r      <= 1'b0;
			sel_d_r    <= 1'b0;
			paused_r   <= 1'b0;
			lane_out   <= 4'h0;
			lane_oe    <= 4'h0;
		end else begin
			sel_d_r <= sel;
			if (wr_ctrl && wstrb_r[0]) begin
				proto_r    <= wdata_r[`FLS_CTRL_PROTO_MSB:`FLS_CTRL_PROTO_LSB];
				dtr_r      <= wdata_r[`FLS_CTRL_DTR];
				pause_en_r <= wdata_r[`FLS_CTRL_PAUSE_EN];
			end
			if (busy)
				busy_cnt_r <= busy_cnt_r - 16'h0001;
			// Status write from the link; protection checked at deselect
			if (commit && !protect) begin
				sr_r[7:2]  <= wdat_r[7:2];
				busy_cnt_r <= WSR_CYCLES;
			end else if (wr_sreg && wstrb_r[0])
				sr_r <= wdata_r[7:0] & `FLS_SR_NV_MASK;
			// Set wins over the software clear
			if (refuse)
				refused_r <= 1'b1;
			else if (wr_state && wstrb_r[1] && wdata_r[`FLS_ST_REFUSED])
				refused_r <= 1'b0;

			if (!sel) begin
				phase_r  <= `FLS_PH_CMD;
				form_r   <= proto_form;
				cnt_r    <= 4'h0;
				wfull_r  <= 1'b0;
				drv_r    <= 1'b0;
				paused_r <= 1'b0;
				lane_out <= 4'h0;
				lane_oe  <= 4'h0;
			end else if (hold) begin
				paused_r <= 1'b1;
				lane_oe  <= 4'h0;
			end else begin
				paused_r <= 1'b0;
				lane_oe  <= drv_r ? fls_oe(form_r) : 4'h0;
				case (phase_r)
				`FLS_PH_CMD: begin
					if (rise) begin
						sh_r <= sh_nxt;
						if (cnt_sum == 4'h8) begin
							cnt_r  <= 4'h0;
							oreg_r <= sr_view;
							if (sh_nxt == OP_WR_STATUS)
								phase_r <= `FLS_PH_WDATA;
							else if (sh_nxt == OP_RD_STATUS)
								phase_r <= `FLS_PH_RDATA;
							else if (sh_nxt == OP_QUAD_OUT ||
								sh_nxt == OP_QUAD_IO) begin
								phase_r <= `FLS_PH_RDATA;
								form_r  <= `FLS_FORM_QUAD;
							end else if (proto_r != `FLS_FORM_QUAD &&
								(sh_nxt == OP_DUAL_OUT ||
								sh_nxt == OP_DUAL_IO)) begin
								phase_r <= `FLS_PH_RDATA;
								form_r  <= `FLS_FORM_DUAL;
							end else
								phase_r <= `FLS_PH_DONE;
						end else
							cnt_r <= cnt_sum;
					end
				end
				`FLS_PH_WDATA: begin
					if (in_edge && !wfull_r) begin
						sh_r <= sh_nxt;
						if (cnt_sum == 4'h8) begin
							wfull_r <= 1'b1;
							wdat_r  <= sh_nxt;
						end else
							cnt_r <= cnt_sum;
					end
				end
				`FLS_PH_RDATA: begin
					if (out_edge) begin
						// Lane sets per form: one, one-zero, or all four
						lane_out <= fls_chunk(oreg_r, form_r);
						lane_oe  <= fls_oe(form_r);
						drv_r    <= 1'b1;
						if (cnt_sum == 4'h8) begin
							cnt_r  <= 4'h0;
							oreg_r <= sr_view;
						end else begin
							cnt_r  <= cnt_sum;
							oreg_r <= oreg_r << w;
						end
					end
				end
				default: begin
					phase_r <= `FLS_PH_DONE;
				end
				endcase
			end
		end
	end

	// AXI4-Lite slave: one write and one read at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			awaddr_r      <= 4'h0;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FLS_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `FLS_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r      <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r      <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ctrl | wr_sreg | wr_state) ?
					`FLS_RESP_OKAY : `FLS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_got_r      <= 1'b0;
				w_got_r       <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `FLS_RESP_OKAY;
				case (s_axi_araddr)
				`FLS_OFF_CTRL:  s_axi_rdata <= {28'h0000000, pause_en_r,
					dtr_r, proto_r};
				`FLS_OFF_SREG:  s_axi_rdata <= {24'h000000, sr_view};
				`FLS_OFF_STATE: s_axi_rdata <= state_word;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `FLS_RESP_SLVERR;
				end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // fls_lane_select
`default_nettype wire

// *** dv/fls_chk.sv ***
// Concurrent checks on the lane select block's ports.
// Assumes one aclk domain and binding onto fls_lane_select.
`timescale 1ns/1ps
`default_nettype none
module fls_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// AXI handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Serial pins
	input wire logic        cs_n,
	input wire logic [3:0]  lane_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_float: assert property ($rose(aresetn) |-> lane_oe == 4'h0)
		else $error("lanes driven after reset");
	a_desel_float: assert property (cs_n [*8] |-> lane_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_lane_shape: assert property (lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal lane drive pattern");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_w_ready_low: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
	a_r_next: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule // fls_chk
bind fls_lane_select fls_chk u_chk (.*);
`default_nettype wire

// *** dv/fls_host.sv ***
// Behavioural serial host facing the lane select block.
// Assumes frame() is called from the bench; sclk idles low outside it.
`timescale 1ns/1ps
`default_nettype none
module fls_host (
	// Device side
	input  wire logic [3:0] lane_out,
	input  wire logic [3:0] lane_oe,
	// Host drive
	output var  logic       sclk,
	output var  logic       cs_n,
	output wire logic [3:0] lane_in
);
	logic [3:0] hd = 4'hF;
	logic [3:0] hen = 4'hC;
	logic       tog = 1'b0;
	logic       wp = 1'b1;
	logic       pz = 1'b1;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// Released lanes toggle so a stale value never reads as valid
	always #7 tog = ~tog;
	assign lane_in = lane_oe & lane_out
		| ~lane_oe & (hen & hd | ~hen & {4{tog}});
	task automatic frame(input int cn, input int dn, input logic [15:0] s,
		input int nb, output logic [7:0] q, output logic [3:0] o);
		int k;
		logic [3:0] m;
		m = 4'((1 << cn) - 1);
		q = 8'h00;
		o = 4'h0;
		hen = m | 4'hC;
		cs_n = 1'b0;
		for (k = 0; k < nb; k += cn) begin
			hd = 4'(s >> (16 - k - cn)) & m | {pz, wp, 2'b00} & ~m;
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		m = 4'((1 << dn) - 1);
		hen = 4'hC & ~m;
		for (k = 0; k < 8 * (dn > 0); k += dn) begin
			#80 sclk = 1'b1;
			q = q << dn | (dn == 1 ? 8'(lane_in[1]) : 8'(lane_in & m));
			o = lane_oe;
			#80 sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		hen = 4'hC;
		#400;
	endtask
endmodule // fls_host
`default_nettype wire

// *** dv/fls_tb.sv ***
// Self-checking bench: AXI4-Lite register tasks and serial host frames.
// Assumes the header constants and the fls_host model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "fls_regs.vh"
module tb;
	logic        aclk, aresetn, sclk, cs_n, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, lane_in, lane_out;
	logic [3:0]  lane_oe, o;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [27:0] r;
	logic [7:0]  q;
	int          bad_count = 0, samples_checked = 0, cyc = 0;
	// Rows: ctrl, command lanes, data lanes, opcode, pause pin, lane drive
	logic [27:0] t [7] = '{28'h9_2_2_05_1_3, 28'h8_1_2_3B_1_3,
		28'h8_1_4_6B_1_F, 28'h8_1_4_EB_1_F, 28'hA_4_4_05_1_F,
		28'h8_1_1_05_0_0, 28'hC_1_1_05_0_2};
	fls_lane_select #(.WSR_CYCLES(16'h0004)) DUT (.*);
	fls_host h (.*);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			conclude;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid | s_axi_wvalid);
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(lane_oe, 4'h0);
		rd(`FLS_OFF_CTRL);
		chk(d, 32'h8);
		rd(4'hC);
		chk(rs, `FLS_RESP_SLVERR);
		wr(4'hC, 32'h1);
		chk(rs, `FLS_RESP_SLVERR);
		$display("test registers done");
		wr(`FLS_OFF_SREG, 32'h80);
		chk(rs, `FLS_RESP_OKAY);
		h.frame(1, 1, 16'h0500, 8, q, o);
		chk(o, 4'h2);
		chk(q, 8'h80);
		$display("test single read done");
		h.wp = 1'b0;
		h.frame(1, 0, 16'h0104, 16, q, o);
		rd(`FLS_OFF_STATE);
		chk(d[8], 1'b1);
		wr(`FLS_OFF_STATE, 32'h100);
		rd(`FLS_OFF_STATE);
		chk(d[8], 1'b0);
		rd(`FLS_OFF_SREG);
		chk(d, 32'h80);
		h.wp = 1'b1;
		h.frame(1, 0, 16'h010C, 16, q, o);
		repeat (20) @(posedge aclk);
		rd(`FLS_OFF_SREG);
		chk(d, 32'h0C);
		$display("test protect done");
		foreach (t[i]) begin
			r = t[i];
			wr(`FLS_OFF_CTRL, {28'h0, r[27:24]});
			h.pz = r[4];
			h.frame(r[23:20], r[19:16], {r[15:8], 8'h00}, 8, q, o);
			chk(o, r[3:0]);
			if (r[3:0] > 4'h2) chk(q, 8'h0C);
		end
		chk(lane_oe, 4'h0);
		$display("test lane forms done");
		conclude;
	end
endmodule // tb
`default_nettype wire
